// ==== shared/agcpk_cfg.svh ====
`ifndef AGCPK_CFG_SVH
`define AGCPK_CFG_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define AGCPK_OFS_CTRL      8'h00
`define AGCPK_OFS_PERIOD    8'h04
`define AGCPK_OFS_SETTLE    8'h08
`define AGCPK_OFS_FRPERIOD  8'h0c
`define AGCPK_OFS_LIMIT_A   8'h10
`define AGCPK_OFS_LIMIT_B   8'h14
`define AGCPK_OFS_STEPS     8'h18
`define AGCPK_OFS_INTERVAL  8'h1c
`define AGCPK_OFS_GAINLIM   8'h20
`define AGCPK_OFS_GAIN      8'h24
`define AGCPK_OFS_STATUS    8'h28

// ****************************************
// Control fields
// ****************************************
`define AGCPK_CTRL_MODE     0
`define AGCPK_CTRL_FA_LO    1
`define AGCPK_CTRL_FA_HI    2
`define AGCPK_CTRL_FR       3

// ****************************************
// Event channels
// ****************************************
`define AGCPK_NCH           6
`define AGCPK_CH_AN_OVER    0
`define AGCPK_CH_AN_UNDER   1
`define AGCPK_CH_HB_OVER    2
`define AGCPK_CH_HB_HIGH    3
`define AGCPK_CH_HB_MID     4
`define AGCPK_CH_HB_LOW     5

// ****************************************
// Reset values
// ****************************************
`define AGCPK_RST_MODE      1'b1
`define AGCPK_RST_PERIOD    16'h0100
`define AGCPK_RST_SETTLE    16'h0010
`define AGCPK_RST_FRPERIOD  16'h0040
`define AGCPK_RST_LIMIT     8'h04
`define AGCPK_RST_STEP      4'h1
`define AGCPK_RST_IVL       8'h02
`define AGCPK_RST_GMAX      8'hff
`define AGCPK_RST_GMIN      8'h00
`define AGCPK_RST_GAIN      8'hff

`endif

// ==== shared/agcpk_pkg.sv ====
package agcpk_pkg;

   typedef enum logic {
      AGCPK_COUNT,
      AGCPK_SETTLE
   } agcpk_phase_t;

   typedef struct packed {
      logic             mode;
      logic [1:0]       fast_attack_select;
      logic             fast_recovery_enable;
      logic [15:0]      update_period_cycles;
      logic [15:0]      settling_delay_cycles;
      logic [15:0]      fast_recovery_period;
      logic [5:0][7:0]  limit;
      logic [5:0][3:0]  step;
      logic [7:0]       mid_period_count;
      logic [7:0]       high_recovery_period_count;
      logic [7:0]       gain_max;
      logic [7:0]       gain_min;
   } agcpk_cfg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } agcpk_bus_t;

   typedef struct packed {
      agcpk_cfg_t   cfg;
      agcpk_phase_t phase;
      logic [15:0]  tmr;
      logic [15:0]  holdoff;
      logic [7:0]   gain;
      logic         gain_chg;
      logic         gain_dec;
      logic         expiry;
      logic [7:0]   ivl;
      logic [1:0]   top;
      logic [31:0]  rdata;
   } agcpk_state_t;

endpackage

// ==== rtl/agcpk_evt_cnt.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "agcpk_cfg.svh"

module agcpk_evt_cnt (
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic [`AGCPK_NCH-1:0]        hit,
   input  wire logic [`AGCPK_NCH-1:0]        clr,
   input  wire logic [`AGCPK_NCH-1:0][7:0]   limit,
   output logic      [`AGCPK_NCH-1:0]        reached
);

   typedef struct packed {
      logic [`AGCPK_NCH-1:0][7:0] cnt;
   } agcpk_cnt_t;

   agcpk_cnt_t cnt_ff;
   agcpk_cnt_t nxt_cnt;

   // ****************************************
   // Saturating peak counters, one per threshold
   // ****************************************
   for (genvar i = 0; i < `AGCPK_NCH; i++) begin : g_ch
      assign nxt_cnt.cnt[i] = clr[i] ? 8'h00 :
                              (hit[i] && cnt_ff.cnt[i] != 8'hff) ? cnt_ff.cnt[i] + 8'h01 :
                              cnt_ff.cnt[i];
      // Flag once the peak count reaches the programmed number
      assign reached[i] = cnt_ff.cnt[i] >= limit[i];
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule
`default_nettype wire

// ==== rtl/agcpk_core.sv ====
// Overview of operation
// - Normal gain changes happen only when the programmable update counter expires.
// - Update interval equals settling delay plus update counter period.
// - Every expiry clears all peak event counters.
// - Analog overrange at expiry lowers gain by analog attack step.
// - Analog underrange at expiry raises gain by analog recovery step.
// - Peaks between thresholds leave the gain index unchanged.
// - Fast attack field bit 0 analog, bit 1 halfband; cleared bits defer.
// - Fast attack decrements once the count reaches its limit, repeatedly.
// - Fast recovery times the period with the fast recovery period.
// - Fast recovery below low level raises by low step each period.
// - Between low and mid level, raise by mid step after programmed periods.
// - Between mid and high level, raise by high step after high period count.
// - Recovery increments occur only at period expiry.
// - Both overranges apply analog attack step; halfband step only alone.
// - Recovery priority: halfband low, mid, high, then analog.
// - A single analog underrange applies its own recovery step; a lone halfband one does not.
// - Enough analog low threshold peaks block all recovery that period.
// - Halfband high threshold exceeded does not block analog recovery.
// - Zero winning step falls back to next active nonzero step.
// - Overrange when count reaches limit; underrange when it does not.
// - Mode one is peak detect; zero is peak and power.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "agcpk_cfg.svh"

module agcpk_core (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [31:0] rd_data,
   input  wire logic        analog_over_hit,
   input  wire logic        analog_under_hit,
   input  wire logic        halfband_over_hit,
   input  wire logic        halfband_under_high_hit,
   input  wire logic        halfband_under_mid_hit,
   input  wire logic        halfband_under_low_hit,
   output logic      [7:0]  gain_index,
   output logic             gain_change,
   output logic             gain_decrease,
   output logic             update_expiry
);

   agcpk_pkg::agcpk_state_t st_ff;
   agcpk_pkg::agcpk_state_t nxt_st;
   agcpk_pkg::agcpk_bus_t   bus;

   logic [5:0]  hit;
   logic [5:0]  clr;
   logic [5:0]  reached;
   logic        expire;
   logic        over_an;
   logic        over_hb;
   logic        fast_an;
   logic        fast_hb;
   logic        gain_wr;
   logic        rec_go;
   logic        ivl_hit;
   logic [3:0]  att_step;
   logic [3:0]  rec_step;
   logic [15:0] per_sel;
   logic [1:0]  top;
   logic [3:0]  cand;
   logic [3:0][3:0] cstep;

   assign bus = '{wr: wr_en, rd: rd_en, addr: addr, wdata: wr_data};
   assign hit = {halfband_under_low_hit, halfband_under_mid_hit, halfband_under_high_hit,
                 halfband_over_hit, analog_under_hit, analog_over_hit};

   agcpk_evt_cnt u_cnt (
      .clk     (clk),
      .reset   (reset),
      .hit     (hit),
      .clr     (clr),
      .limit   (st_ff.cfg.limit),
      .reached (reached)
   );

   function automatic logic [7:0] sat_dn(input logic [7:0] g, input logic [3:0] s, input logic [7:0] lo);
      if ({1'b0, g} < {1'b0, lo} + {5'h00, s}) begin
         return lo;
      end
      return g - {4'h0, s};
   endfunction

   function automatic logic [7:0] sat_up(input logic [7:0] g, input logic [3:0] s, input logic [7:0] hi);
      if ({1'b0, g} + {5'h00, s} > {1'b0, hi}) begin
         return hi;
      end
      return g + {4'h0, s};
   endfunction

   // ****************************************
   // Decision logic
   // ****************************************
   always_comb begin
      nxt_st   = st_ff;
      nxt_st.gain_chg = 1'b0;
      nxt_st.gain_dec = 1'b0;
      nxt_st.expiry   = 1'b0;
      nxt_st.rdata    = 32'h0000_0000;
      clr      = 6'h00;
      gain_wr  = bus.wr && bus.addr == `AGCPK_OFS_GAIN;

      // Period source swaps under fast recovery
      per_sel = st_ff.cfg.fast_recovery_enable ? st_ff.cfg.fast_recovery_period
                                               : st_ff.cfg.update_period_cycles;
      if (per_sel == 16'h0000) begin
         per_sel = 16'h0001;
      end
      expire = st_ff.phase == agcpk_pkg::AGCPK_COUNT && st_ff.tmr >= per_sel - 16'h0001;

      // Timer: counting phase then settling phase
      nxt_st.tmr = st_ff.tmr + 16'h0001;
      if (expire) begin
         nxt_st.tmr = 16'h0000;
         if (st_ff.cfg.settling_delay_cycles != 16'h0000) begin
            nxt_st.phase = agcpk_pkg::AGCPK_SETTLE;
         end
      end else if (st_ff.phase == agcpk_pkg::AGCPK_SETTLE &&
                   st_ff.tmr >= st_ff.cfg.settling_delay_cycles - 16'h0001) begin
         nxt_st.tmr   = 16'h0000;
         nxt_st.phase = agcpk_pkg::AGCPK_COUNT;
      end
      if (st_ff.holdoff != 16'h0000) begin
         nxt_st.holdoff = st_ff.holdoff - 16'h0001;
      end

      over_an = reached[`AGCPK_CH_AN_OVER];
      over_hb = reached[`AGCPK_CH_HB_OVER];
      fast_an = st_ff.cfg.fast_attack_select[0] && over_an;
      fast_hb = st_ff.cfg.fast_attack_select[1] && over_hb;

      // Underrange level ranking; halfband low and mid exist only in fast recovery
      if (st_ff.cfg.fast_recovery_enable && !reached[`AGCPK_CH_HB_LOW]) begin
         top = 2'd3;
      end else if (st_ff.cfg.fast_recovery_enable && !reached[`AGCPK_CH_HB_MID]) begin
         top = 2'd2;
      end else if (!reached[`AGCPK_CH_HB_HIGH]) begin
         top = 2'd1;
      end else begin
         top = 2'd0;
      end
      ivl_hit = (top == 2'd2) ? ({1'b0, st_ff.ivl} + 9'h001 >= {1'b0, st_ff.cfg.mid_period_count})
                              : ({1'b0, st_ff.ivl} + 9'h001 >= {1'b0, st_ff.cfg.high_recovery_period_count});

      // Candidates in priority order: low, mid, high, analog
      cand[0] = top == 2'd3;
      cand[1] = top >= 2'd2 && (top != 2'd2 || ivl_hit);
      cand[2] = top >= 2'd1 && (top != 2'd1 || !st_ff.cfg.fast_recovery_enable || ivl_hit);
      cand[3] = !reached[`AGCPK_CH_AN_UNDER];
      cstep[0] = st_ff.cfg.step[`AGCPK_CH_HB_LOW];
      cstep[1] = st_ff.cfg.step[`AGCPK_CH_HB_MID];
      cstep[2] = st_ff.cfg.step[`AGCPK_CH_HB_HIGH];
      cstep[3] = st_ff.cfg.step[`AGCPK_CH_AN_UNDER];
      rec_step = 4'h0;
      for (int i = 3; i >= 0; i--) begin
         if (cand[i] && cstep[i] != 4'h0) begin
            rec_step = cstep[i];
         end
      end

      att_step = over_an ? st_ff.cfg.step[`AGCPK_CH_AN_OVER]
                         : st_ff.cfg.step[`AGCPK_CH_HB_OVER];
      rec_go   = expire && st_ff.cfg.mode && !over_an && !over_hb &&
                 !reached[`AGCPK_CH_AN_UNDER] && rec_step != 4'h0;

      if (expire) begin
         clr = 6'h3f;
         nxt_st.expiry = 1'b1;
         if (over_an || over_hb) begin
            nxt_st.gain     = sat_dn(st_ff.gain, att_step, st_ff.cfg.gain_min);
            nxt_st.gain_chg = 1'b1;
            nxt_st.gain_dec = 1'b1;
            nxt_st.holdoff  = st_ff.cfg.settling_delay_cycles;
         end else if (rec_go) begin
            nxt_st.gain     = sat_up(st_ff.gain, rec_step, st_ff.cfg.gain_max);
            nxt_st.gain_chg = 1'b1;
         end
         // Interval count runs while the same level persists
         nxt_st.top = top;
         if (top == 2'd0 || top != st_ff.top || rec_go) begin
            nxt_st.ivl = 8'h00;
         end else if (st_ff.ivl != 8'hff) begin
            nxt_st.ivl = st_ff.ivl + 8'h01;
         end
      end else if ((fast_an || fast_hb) && st_ff.holdoff == 16'h0000) begin
         // Immediate attack, then rearm the firing detector, plus the halfband one on an analog attack
         nxt_st.gain     = sat_dn(st_ff.gain, att_step, st_ff.cfg.gain_min);
         nxt_st.gain_chg = 1'b1;
         nxt_st.gain_dec = 1'b1;
         nxt_st.holdoff  = st_ff.cfg.settling_delay_cycles;
         clr[`AGCPK_CH_AN_OVER] = fast_an;
         clr[`AGCPK_CH_HB_OVER] = fast_an || fast_hb;
      end

      // ****************************************
      // Register writes
      // ****************************************
      if (bus.wr) begin
         if (bus.addr == `AGCPK_OFS_CTRL) begin
            nxt_st.cfg.mode                 = bus.wdata[`AGCPK_CTRL_MODE];
            nxt_st.cfg.fast_attack_select   = bus.wdata[`AGCPK_CTRL_FA_HI:`AGCPK_CTRL_FA_LO];
            nxt_st.cfg.fast_recovery_enable = bus.wdata[`AGCPK_CTRL_FR];
         end else if (bus.addr == `AGCPK_OFS_PERIOD) begin
            nxt_st.cfg.update_period_cycles = bus.wdata[15:0];
         end else if (bus.addr == `AGCPK_OFS_SETTLE) begin
            nxt_st.cfg.settling_delay_cycles = bus.wdata[15:0];
         end else if (bus.addr == `AGCPK_OFS_FRPERIOD) begin
            nxt_st.cfg.fast_recovery_period = bus.wdata[15:0];
         end else if (bus.addr == `AGCPK_OFS_LIMIT_A) begin
            nxt_st.cfg.limit[3:0] = bus.wdata;
         end else if (bus.addr == `AGCPK_OFS_LIMIT_B) begin
            nxt_st.cfg.limit[5:4] = bus.wdata[15:0];
         end else if (bus.addr == `AGCPK_OFS_STEPS) begin
            nxt_st.cfg.step = bus.wdata[23:0];
         end else if (bus.addr == `AGCPK_OFS_INTERVAL) begin
            nxt_st.cfg.mid_period_count           = bus.wdata[7:0];
            nxt_st.cfg.high_recovery_period_count = bus.wdata[15:8];
         end else if (bus.addr == `AGCPK_OFS_GAINLIM) begin
            nxt_st.cfg.gain_max = bus.wdata[7:0];
            nxt_st.cfg.gain_min = bus.wdata[15:8];
         end else if (gain_wr) begin
            // Software load overrides any change in the same cycle
            nxt_st.gain     = bus.wdata[7:0];
            nxt_st.gain_chg = 1'b0;
            nxt_st.gain_dec = 1'b0;
         end
      end

      // ****************************************
      // Register reads, data valid next cycle only
      // ****************************************
      if (bus.rd) begin
         if (bus.addr == `AGCPK_OFS_CTRL) begin
            nxt_st.rdata = {28'h0, st_ff.cfg.fast_recovery_enable, st_ff.cfg.fast_attack_select,
                            st_ff.cfg.mode};
         end else if (bus.addr == `AGCPK_OFS_PERIOD) begin
            nxt_st.rdata = {16'h0, st_ff.cfg.update_period_cycles};
         end else if (bus.addr == `AGCPK_OFS_SETTLE) begin
            nxt_st.rdata = {16'h0, st_ff.cfg.settling_delay_cycles};
         end else if (bus.addr == `AGCPK_OFS_FRPERIOD) begin
            nxt_st.rdata = {16'h0, st_ff.cfg.fast_recovery_period};
         end else if (bus.addr == `AGCPK_OFS_LIMIT_A) begin
            nxt_st.rdata = st_ff.cfg.limit[3:0];
         end else if (bus.addr == `AGCPK_OFS_LIMIT_B) begin
            nxt_st.rdata = {16'h0, st_ff.cfg.limit[5:4]};
         end else if (bus.addr == `AGCPK_OFS_STEPS) begin
            nxt_st.rdata = {8'h0, st_ff.cfg.step};
         end else if (bus.addr == `AGCPK_OFS_INTERVAL) begin
            nxt_st.rdata = {16'h0, st_ff.cfg.high_recovery_period_count, st_ff.cfg.mid_period_count};
         end else if (bus.addr == `AGCPK_OFS_GAINLIM) begin
            nxt_st.rdata = {16'h0, st_ff.cfg.gain_min, st_ff.cfg.gain_max};
         end else if (bus.addr == `AGCPK_OFS_GAIN) begin
            nxt_st.rdata = {24'h0, st_ff.gain};
         end else if (bus.addr == `AGCPK_OFS_STATUS) begin
            nxt_st.rdata = {14'h0, st_ff.top, st_ff.ivl, 1'b0, st_ff.phase, reached};
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff <= '0;
         st_ff.cfg.mode                       <= `AGCPK_RST_MODE;
         st_ff.cfg.update_period_cycles       <= `AGCPK_RST_PERIOD;
         st_ff.cfg.settling_delay_cycles      <= `AGCPK_RST_SETTLE;
         st_ff.cfg.fast_recovery_period       <= `AGCPK_RST_FRPERIOD;
         st_ff.cfg.limit                      <= {6{`AGCPK_RST_LIMIT}};
         st_ff.cfg.step                       <= {6{`AGCPK_RST_STEP}};
         st_ff.cfg.mid_period_count           <= `AGCPK_RST_IVL;
         st_ff.cfg.high_recovery_period_count <= `AGCPK_RST_IVL;
         st_ff.cfg.gain_max                   <= `AGCPK_RST_GMAX;
         st_ff.cfg.gain_min                   <= `AGCPK_RST_GMIN;
         st_ff.gain                           <= `AGCPK_RST_GAIN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rd_data       = st_ff.rdata;
   assign gain_index    = st_ff.gain;
   assign gain_change   = st_ff.gain_chg;
   assign gain_decrease = st_ff.gain_dec;
   assign update_expiry = st_ff.expiry;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Gap between expiries, invalidated by any write
   logic [17:0] gap_ff;
   logic        gap_ok_ff;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         gap_ff    <= 18'h00000;
         gap_ok_ff <= 1'b0;
      end else begin
         gap_ff    <= expire ? 18'h00001 : gap_ff + 18'h00001;
         gap_ok_ff <= wr_en ? 1'b0 : (expire ? 1'b1 : gap_ok_ff);
      end
   end

   a_gain_in_range: assert property (gain_change |->
      gain_index <= st_ff.cfg.gain_max && gain_index >= st_ff.cfg.gain_min)
      else $error("gain index outside limits");
   a_recovery_at_expiry: assert property (gain_change && !gain_decrease |-> update_expiry)
      else $error("recovery away from period expiry");
   a_recovery_blocked: assert property (expire && reached[1] |=> !(gain_change && !gain_decrease))
      else $error("recovery despite analog low peaks");
   a_attack_analog_wins: assert property (expire && over_an && !gain_wr |=>
      gain_change && gain_decrease && gain_index == sat_dn($past(gain_index), $past(st_ff.cfg.step[0]),
      $past(st_ff.cfg.gain_min)))
      else $error("analog attack step not applied");
   a_period_spacing: assert property (expire && gap_ok_ff && !wr_en && !st_ff.cfg.fast_recovery_enable |->
      gap_ff == {2'b00, st_ff.cfg.update_period_cycles} + {2'b00, st_ff.cfg.settling_delay_cycles})
      else $error("update interval wrong");
   a_stable_hold: assert property (expire && !over_an && !over_hb && reached[1] && reached[3] && !gain_wr
      && !st_ff.cfg.fast_recovery_enable |=> !gain_change && $stable(gain_index))
      else $error("gain moved in stable window");
   a_fast_attack_now: assert property (!expire && fast_an && st_ff.holdoff == 16'h0000 && !gain_wr
      |=> gain_change && gain_decrease)
      else $error("fast attack missed");
   a_deferred_attack: assert property (gain_change && gain_decrease && $past(st_ff.cfg.fast_attack_select)
      == 2'b00 |-> update_expiry)
      else $error("attack before expiry without fast attack");
   a_mode_no_recovery: assert property (!st_ff.cfg.mode |=> !(gain_change && !gain_decrease))
      else $error("peak recovery in combined mode");
   a_counters_cleared: assert property (expire ##1 !$past(hit[1]) |-> !reached[1] ||
      st_ff.cfg.limit[1] == 8'h00)
      else $error("counters not cleared at expiry");

   c_fast_attack: cover property (!expire && fast_an ##1 gain_change && gain_decrease);
   c_recovery: cover property (gain_change && !gain_decrease);
   c_fast_rec_mid: cover property (expire && top == 2'd2 && ivl_hit && st_ff.cfg.fast_recovery_enable);
   c_saturate: cover property (gain_change && gain_index == st_ff.cfg.gain_min);

endmodule
`default_nettype wire

// ==== tb/agcpk_peak_src.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Receive chain peak detector stand-in
// ****************************************
module agcpk_peak_src (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [5:0] mask,
   output logic      [5:0] hits
);
   // One hit per cycle on each level the signal peaks exceed
   // Every level follows its own mask bit independently, one cycle later
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hits <= 6'h00;
      end else begin
         hits <= mask;
      end
   end
endmodule

`default_nettype wire

// ==== tb/agc_peak_gain_decision_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "agcpk_cfg.svh"

module agc_peak_gain_decision_bench;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wr_data = 32'h0;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [31:0] rd_data;
   logic [5:0]  mask = 6'h0a;
   logic [5:0]  hits;
   logic [7:0]  gain_index;
   logic        gain_change;
   logic        gain_decrease;
   logic        update_expiry;
   logic [31:0] rv;
   int          fail_count = 0;
   int          comparisons = 0;
   int          gap;
   int          k;

   always #4 clk = ~clk;

   agcpk_peak_src src (.clk(clk), .reset(reset), .mask(mask), .hits(hits));

   agcpk_core DUT (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .analog_over_hit(hits[0]), .analog_under_hit(hits[1]),
      .halfband_over_hit(hits[2]), .halfband_under_high_hit(hits[3]), .halfband_under_mid_hit(hits[4]),
      .halfband_under_low_hit(hits[5]), .gain_index(gain_index), .gain_change(gain_change),
      .gain_decrease(gain_decrease), .update_expiry(update_expiry));

   // ****************************************
   // Access and check tasks
   // ****************************************
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      d = rd_data;
   endtask

   // Gap between expiry pulses, bounded so a dead timer cannot hang
   task automatic wait_exp;
      gap = 1;
      @(posedge clk);
      while (update_expiry !== 1'b1 && gap < 100) begin
         @(posedge clk);
         gap++;
      end
      if (gap >= 100) chk("expiry", 32'h1, 32'h0);
   endtask

   // Discard the mixed window, load the gain, then judge n full windows
   task automatic run(input logic [31:0] ctrl, input logic [5:0] m, input int n,
                      input logic [7:0] g0, input logic [7:0] exp);
      mask <= m;
      wr(`AGCPK_OFS_CTRL, ctrl);
      wait_exp;
      wr(`AGCPK_OFS_GAIN, {24'h0, g0});
      repeat (n) wait_exp;
      chk("gain_index", {24'h0, exp}, {24'h0, gain_index});
   endtask

   task automatic wait_change;
      k = 0;
      @(posedge clk);
      while (gain_change !== 1'b1 && k < 12) begin
         @(posedge clk);
         k++;
      end
   endtask

   task conclude;
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #200us;
      fail_count++;
      conclude();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd(`AGCPK_OFS_CTRL, rv);    chk("ctrl", 32'h1, rv);
      rd(`AGCPK_OFS_GAIN, rv);    chk("gain", 32'hff, rv);
      rd(`AGCPK_OFS_PERIOD, rv);  chk("period", 32'h100, rv);
      rd(`AGCPK_OFS_STEPS, rv);   chk("steps", 32'h111111, rv);
      rd(8'h30, rv);              chk("unmapped", 32'h0, rv);
      wr(`AGCPK_OFS_PERIOD, 32'h8);
      wr(`AGCPK_OFS_SETTLE, 32'h2);
      wr(`AGCPK_OFS_FRPERIOD, 32'h4);
      wr(`AGCPK_OFS_LIMIT_A, 32'h02020202);
      wr(`AGCPK_OFS_LIMIT_B, 32'h0202);
      wr(`AGCPK_OFS_STEPS, 32'h641523);
      wr(`AGCPK_OFS_INTERVAL, 32'h0101);
      wr(`AGCPK_OFS_GAINLIM, 32'h10ff);
      rd(`AGCPK_OFS_STEPS, rv);   chk("steps", 32'h641523, rv);
      wait_exp;
      wait_exp;                   chk("gap", 32'd10, gap);
      run(32'h1, 6'h0b, 2, 8'h80, 8'h7a);
      run(32'h1, 6'h0f, 1, 8'h80, 8'h7d);
      run(32'h1, 6'h0e, 1, 8'h80, 8'h7b);
      run(32'h1, 6'h0a, 2, 8'h80, 8'h80);
      run(32'h1, 6'h08, 2, 8'h80, 8'h84);
      run(32'h1, 6'h02, 1, 8'h80, 8'h80);
      run(32'h1, 6'h00, 1, 8'h80, 8'h81);
      run(32'h1, 6'h0b, 2, 8'h13, 8'h10);
      run(32'h0, 6'h00, 1, 8'h80, 8'h80);
      run(32'h9, 6'h00, 1, 8'h80, 8'h86);
      wait_exp;                   chk("gap_fast", 32'd6, gap);
      run(32'h9, 6'h00, 1, 8'hfe, 8'hff);
      run(32'h9, 6'h20, 1, 8'h80, 8'h84);
      run(32'h9, 6'h30, 1, 8'h80, 8'h81);
      run(32'h9, 6'h02, 1, 8'h80, 8'h80);
      wr(`AGCPK_OFS_STEPS, 32'h000523);
      run(32'h9, 6'h00, 1, 8'h80, 8'h82);
      wr(`AGCPK_OFS_STEPS, 32'h641523);
      // Fast attack on the analog detector well before the window ends
      run(32'h3, 6'h0a, 1, 8'h80, 8'h80);
      mask <= 6'h0b;
      wait_change;
      chk("fast_early", 32'h1, {31'h0, k < 7});
      chk("fast_dec", 32'h1, {31'h0, gain_decrease});
      chk("fast_gain", 32'h7d, {24'h0, gain_index});
      wait_change;
      chk("fast_again", 32'h7a, {24'h0, gain_index});
      // Halfband fast attack only
      run(32'h5, 6'h0a, 1, 8'h80, 8'h80);
      mask <= 6'h0e;
      wait_change;
      chk("hb_fast_early", 32'h1, {31'h0, k < 7});
      chk("hb_fast_gain", 32'h7b, {24'h0, gain_index});
      conclude();
   end
endmodule

`default_nettype wire
